// ### gmc_pkg.sv
// gpio_mode_control constants, modes and carrier types.
// assumes a byte-wide host register port in front of the block.
package gmc_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [15:0] GMC_ADDR_SEL0_HI = 16'h00E0;
    localparam logic [15:0] GMC_ADDR_SEL0_LO = 16'h00E1;
    localparam logic [15:0] GMC_ADDR_MODE0   = 16'h00E2;
    localparam logic [15:0] GMC_ADDR_SEL1_HI = 16'h00E3;
    localparam logic [15:0] GMC_ADDR_SEL1_LO = 16'h00E4;
    localparam logic [15:0] GMC_ADDR_OUTVAL  = 16'h00EF;
    localparam logic [15:0] GMC_ADDR_INSTAT  = 16'h0140;

    localparam logic [7:0]  GMC_MODE0_RESET  = 8'h00;
    localparam logic [15:0] GMC_SEL1_RESET   = 16'h0000;

    // ************************************************************
    // field layout
    // ************************************************************
    localparam int GMC_MODE_LSB    = 0;
    localparam int GMC_MODE_MSB    = 2;
    localparam int GMC_SEL_BIT_LSB = 12;
    localparam int GMC_SEL_BIT_MSB = 14;
    localparam int GMC_SEL_PG_LSB  = 8;
    localparam int GMC_SEL_PG_MSB  = 11;
    localparam int GMC_SEL_OFS_LSB = 0;
    localparam int GMC_SEL_OFS_MSB = 6;

    // reserved bits are stored as zero
    localparam logic [7:0]  GMC_MODE_KEEP = 8'h07;
    localparam logic [15:0] GMC_SEL_KEEP  = 16'h7F7F;

    // ************************************************************
    // pin modes
    // ************************************************************
    localparam logic [2:0] GMC_MODE_INPUT   = 3'h0;
    localparam logic [2:0] GMC_MODE_OUTPUT  = 3'h1;
    localparam logic [2:0] GMC_MODE_CONTROL = 3'h2;
    localparam logic [2:0] GMC_MODE_STATUS  = 3'h3;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } gmc_host_req_t;

    typedef struct packed {
        logic [2:0] bit_pos;
        logic [3:0] page;
        logic [6:0] offset;
    } gmc_bit_addr_t;

endpackage

// ### gmc_gpio_mode_control.sv
// pin-zero mode logic and pin-one selector register.
// assumes host requests are synchronous to clk; the pin input passes a two-flop synchroniser;
// selector 0, output-value bit and the addressed host bit come from
// the surrounding register map.
`timescale 1ns/1ns

// What this block does
// - mode bits 2:0 of pin-zero mode register pick behaviour; 7:3 reserved
// - mode 000: pin is input, its level reported as input-status bit 0
// - mode 001: pin driven with output-value register bit 0
// - mode 010: on any pin or selected-bit change, apply their OR
// - mode 011: pin continuously mirrors the selected host register bit
// - pin-one selector bits 14:12 hold the bit position
// - pin-one selector bits 11:8 hold the page
// - pin-one selector bits 6:0 hold the offset; bits 15 and 7 reserved
// - page, offset and bit together name exactly one host register bit
// - selector takes effect only in control or status mode
module gmc_gpio_mode_control
    import gmc_pkg::*;
(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          resetn,
    // host register port
    input  wire gmc_host_req_t host_req,
    output logic [7:0]         host_rdata,
    // surrounding register map
    input  wire logic [15:0]   sel0_value,
    input  wire logic          out_value_bit,
    input  wire logic          selected_bit,
    output gmc_bit_addr_t      selected_addr,
    output logic               in_status_bit,
    output logic [15:0]        sel1_value,
    // controlled function
    output logic               ctrl_apply,
    output logic               ctrl_update,
    // general_pin_zero
    input  wire logic          general_pin_zero_i,
    output logic               general_pin_zero_o,
    output logic               general_pin_zero_oe
);

    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0]    mode_reg,   mode_next;
    logic [15:0]   sel1_reg,   sel1_next;
    logic [7:0]    rdata_reg,  rdata_next;
    logic          sync1_reg,  sync2_reg,  pin_prev_reg;
    logic          bit_prev_reg;
    logic          ctrl_reg,   ctrl_next;
    logic          upd_reg,    upd_next;
    logic          pin_o_reg,  pin_o_next;
    logic          pin_oe_reg, pin_oe_next;
    logic          stat_reg,   stat_next;
    gmc_bit_addr_t addr_reg,   addr_next;
    logic [2:0]    mode;
    logic          sel_active;
    logic          change;

    assign mode       = mode_reg[GMC_MODE_MSB:GMC_MODE_LSB];
    assign sel_active = (mode == GMC_MODE_CONTROL) ||
                        (mode == GMC_MODE_STATUS);
    assign change     = (sync2_reg != pin_prev_reg) ||
                        (selected_bit != bit_prev_reg);

    // ************************************************************
    // host register access
    // ************************************************************
    always_comb
    begin
        mode_next  = mode_reg;
        sel1_next  = sel1_reg;
        rdata_next = rdata_reg;
        if (host_req.wr)
        begin
            case (host_req.addr)
                GMC_ADDR_MODE0:
                    mode_next = host_req.wdata & GMC_MODE_KEEP;
                GMC_ADDR_SEL1_HI:
                    sel1_next[15:8] = host_req.wdata &
                                      GMC_SEL_KEEP[15:8];
                GMC_ADDR_SEL1_LO:
                    sel1_next[7:0] = host_req.wdata &
                                     GMC_SEL_KEEP[7:0];
                default: ;
            endcase
        end
        if (host_req.rd)
        begin
            case (host_req.addr)
                GMC_ADDR_MODE0:   rdata_next = mode_reg;
                GMC_ADDR_SEL1_HI: rdata_next = sel1_reg[15:8];
                GMC_ADDR_SEL1_LO: rdata_next = sel1_reg[7:0];
                default:          rdata_next = 8'h00;
            endcase
        end
    end

    // ************************************************************
    // pin behaviour
    // ************************************************************
    always_comb
    begin
        pin_o_next  = 1'b0;
        pin_oe_next = 1'b0;
        stat_next   = stat_reg;
        ctrl_next   = ctrl_reg;
        upd_next    = 1'b0;
        addr_next   = '0;
        if (sel_active)
        begin
            addr_next.bit_pos = sel0_value[GMC_SEL_BIT_MSB:GMC_SEL_BIT_LSB];
            addr_next.page    = sel0_value[GMC_SEL_PG_MSB:GMC_SEL_PG_LSB];
            addr_next.offset  = sel0_value[GMC_SEL_OFS_MSB:GMC_SEL_OFS_LSB];
        end
        case (mode)
            GMC_MODE_INPUT:
                stat_next = sync2_reg;
            GMC_MODE_OUTPUT:
            begin
                pin_o_next  = out_value_bit;
                pin_oe_next = 1'b1;
            end
            GMC_MODE_CONTROL:
            begin
                if (change)
                begin
                    ctrl_next = sync2_reg | selected_bit;
                    upd_next  = 1'b1;
                end
            end
            GMC_MODE_STATUS:
            begin
                pin_o_next  = selected_bit;
                pin_oe_next = 1'b1;
            end
            default:
                stat_next = sync2_reg;
        endcase
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mode_reg     <= GMC_MODE0_RESET;
            sel1_reg     <= GMC_SEL1_RESET;
            rdata_reg    <= 8'h00;
            sync1_reg    <= 1'b0;
            sync2_reg    <= 1'b0;
            pin_prev_reg <= 1'b0;
            bit_prev_reg <= 1'b0;
            ctrl_reg     <= 1'b0;
            upd_reg      <= 1'b0;
            pin_o_reg    <= 1'b0;
            pin_oe_reg   <= 1'b0;
            stat_reg     <= 1'b0;
            addr_reg     <= '0;
        end
        else
        begin
            mode_reg     <= mode_next;
            sel1_reg     <= sel1_next;
            rdata_reg    <= rdata_next;
            sync1_reg    <= general_pin_zero_i;
            sync2_reg    <= sync1_reg;
            pin_prev_reg <= sync2_reg;
            bit_prev_reg <= selected_bit;
            ctrl_reg     <= ctrl_next;
            upd_reg      <= upd_next;
            pin_o_reg    <= pin_o_next;
            pin_oe_reg   <= pin_oe_next;
            stat_reg     <= stat_next;
            addr_reg     <= addr_next;
        end
    end

    assign host_rdata          = rdata_reg;
    assign sel1_value          = sel1_reg;
    assign selected_addr       = addr_reg;
    assign in_status_bit       = stat_reg;
    assign ctrl_apply          = ctrl_reg;
    assign ctrl_update         = upd_reg;
    assign general_pin_zero_o  = pin_o_reg;
    assign general_pin_zero_oe = pin_oe_reg;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_mode_reserved;
        mode_reg[7:3] == 5'h00;
    endproperty
    a_mode_reserved: assert property (p_mode_reserved)
        else $error("mode reserved bits not zero");

    property p_input_status;
        (mode == GMC_MODE_INPUT) ##1 (mode == GMC_MODE_INPUT)
            |-> in_status_bit == $past(sync2_reg);
    endproperty
    a_input_status: assert property (p_input_status)
        else $error("input status does not follow pin");

    property p_output_drive;
        (mode == GMC_MODE_OUTPUT) && !host_req.wr
            |=> general_pin_zero_oe &&
                general_pin_zero_o == $past(out_value_bit);
    endproperty
    a_output_drive: assert property (p_output_drive)
        else $error("output mode not driving value");

    property p_control_or;
        (mode == GMC_MODE_CONTROL) && change
            |=> ctrl_update &&
                ctrl_apply == ($past(sync2_reg) | $past(selected_bit));
    endproperty
    a_control_or: assert property (p_control_or)
        else $error("control value not the OR of pin and bit");

    property p_status_mirror;
        (mode == GMC_MODE_STATUS) && !host_req.wr
            |=> general_pin_zero_oe &&
                general_pin_zero_o == $past(selected_bit);
    endproperty
    a_status_mirror: assert property (p_status_mirror)
        else $error("status mode not mirroring selected bit");

    property p_sel1_reserved;
        sel1_value[15] == 1'b0 && sel1_value[7] == 1'b0;
    endproperty
    a_sel1_reserved: assert property (p_sel1_reserved)
        else $error("selector reserved bits not zero");

    property p_sel1_write_hi;
        host_req.wr && host_req.addr == GMC_ADDR_SEL1_HI
            |=> sel1_value[14:8] == $past(host_req.wdata[6:0]);
    endproperty
    a_sel1_write_hi: assert property (p_sel1_write_hi)
        else $error("selector high byte not stored");

    property p_addr_idle;
        !sel_active && !$past(sel_active) |-> selected_addr == '0;
    endproperty
    a_addr_idle: assert property (p_addr_idle)
        else $error("selector active outside control or status");

    property p_undriven;
        (mode != GMC_MODE_OUTPUT) && (mode != GMC_MODE_STATUS)
            && !host_req.wr |=> !general_pin_zero_oe;
    endproperty
    a_undriven: assert property (p_undriven)
        else $error("pin driven in input or control mode");

    property p_sync_delay;
        (mode == GMC_MODE_CONTROL) && !host_req.wr && $rose(sync2_reg)
            |=> ctrl_update && ctrl_apply;
    endproperty
    a_sync_delay: assert property (p_sync_delay)
        else $error("control change not applied after sync");

    c_control: cover property ((mode == GMC_MODE_CONTROL) && ctrl_update);
    c_status:  cover property ((mode == GMC_MODE_STATUS) && general_pin_zero_o);
    c_input:   cover property ((mode == GMC_MODE_INPUT) && in_status_bit);
    c_spare:   cover property (mode == 3'h5);

endmodule // gmc_gpio_mode_control

// ### gmc_pin_board.sv
// board-side model of the logic on general_pin_zero.
// assumes the bench sets its drive request off the rising edge.
`timescale 1ns/1ns

module gmc_pin_board
(
    // clock
    input  wire logic clk,
    // block side
    input  wire logic pin_o,
    input  wire logic pin_oe,
    // bench side
    input  wire logic drv_en,
    input  wire logic drv_val,
    output logic      pin_lvl
);
    // ************************************************************
    // wire resolution
    // ************************************************************
    logic flip_reg = 1'b0;

    // a floating pin must not read as the last driven value
    always_ff @(posedge clk)
        flip_reg <= ~flip_reg;

    // outside source drives only while the block lets go
    assign pin_lvl = pin_oe ? pin_o : (drv_en ? drv_val : flip_reg);
endmodule // gmc_pin_board

// ### gmc_gpio_mode_control_tb_top.sv
// self-checking bench for the pin-zero mode logic.
// assumes the block alone, with the register map around it modelled here.
`timescale 1ns/1ns

module gmc_gpio_mode_control_tb_top;
    import gmc_pkg::*;

    // ************************************************************
    // signals
    // ************************************************************
    logic          clk = 1'b0;
    logic          resetn;
    gmc_host_req_t req;
    logic [7:0]    rdata, d;
    logic [15:0]   sel0, sel1;
    logic          outv, selb, ins, capp, cupd;
    gmc_bit_addr_t addr;
    logic          pin_i, pin_o, pin_oe, drv_en, drv_val;
    int            seed = 90;
    int            n_mismatch = 0;
    int            check_count = 0;
    int            v, i, m;
    logic [1:0]    ctl_seq [6] = '{2'b10, 2'b00, 2'b01, 2'b11, 2'b01, 2'b00};

    always #50 clk = ~clk;

    gmc_gpio_mode_control dut (.clk(clk), .resetn(resetn),
        .host_req(req), .host_rdata(rdata), .sel0_value(sel0),
        .out_value_bit(outv), .selected_bit(selb), .selected_addr(addr),
        .in_status_bit(ins), .sel1_value(sel1), .ctrl_apply(capp),
        .ctrl_update(cupd), .general_pin_zero_i(pin_i),
        .general_pin_zero_o(pin_o), .general_pin_zero_oe(pin_oe));

    gmc_pin_board board (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe),
        .drv_en(drv_en), .drv_val(drv_val), .pin_lvl(pin_i));

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [15:0] exp_addr(input logic [15:0] s);
        return {2'b00, s[14:12], s[11:8], s[6:0]};
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        if (n_mismatch == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] dt);
        @(negedge clk);
        req = {1'b1, 1'b0, a, dt};
        @(negedge clk);
        req.wr = 1'b0;
    endtask

    task automatic rd(input logic [15:0] a);
        @(negedge clk);
        req = {1'b0, 1'b1, a, 8'h00};
        @(negedge clk);
        req.rd = 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    // bounded wait for the control pulse, then one-cycle check
    task automatic wait_upd;
        int k;
        k = 0;
        while (cupd !== 1'b1 && k < 8)
        begin
            @(negedge clk);
            k++;
        end
        if (k == 8)
        begin
            n_mismatch++;
            end_sim();
        end
        else
        begin
            chk(capp, ctl_seq[i][1] | ctl_seq[i][0]);
            @(negedge clk);
            chk(cupd, 1'b0);
        end
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        req = '0;
        sel0 = 16'h0000;
        outv = 1'b0;
        selb = 1'b0;
        drv_en = 1'b1;
        drv_val = 1'b0;
        resetn = 1'b0;
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        rd(GMC_ADDR_MODE0);
        chk(d, GMC_MODE0_RESET);
        rd(GMC_ADDR_SEL1_HI);
        chk(d, 16'h0000);
        chk(pin_oe, 1'b0);
        rd(16'h00E5);
        chk(d, 16'h0000);
        for (i = 0; i < 8; i++)
        begin
            v = $random(seed);
            wr(GMC_ADDR_SEL1_HI, v[15:8]);
            wr(GMC_ADDR_SEL1_LO, v[7:0]);
            rd(GMC_ADDR_SEL1_HI);
            chk(d, v[15:8] & 8'h7F);
            rd(GMC_ADDR_SEL1_LO);
            chk(d, v[7:0] & 8'h7F);
            chk(sel1, v[15:0] & 16'h7F7F);
        end
        for (i = 0; i < 16; i++)
        begin
            m = i % 8;
            v = $random(seed);
            wr(GMC_ADDR_MODE0, 8'h00);
            sel0 = v[15:0];
            wr(GMC_ADDR_MODE0, {v[20:16], m[2:0]});
            rd(GMC_ADDR_MODE0);
            chk(d, {5'b0, m[2:0]});
            {outv, selb, drv_val} = v[23:21];
            drv_en = !(m == 1 || m == 3);
            repeat (4) @(negedge clk);
            chk(pin_oe, m == 1 || m == 3);
            if (m == 1 || m == 3)
                chk(pin_o, m == 1 ? outv : selb);
            if (m == 0 || m > 3)
                chk(ins, drv_val);
            chk(addr, (m == 2 || m == 3) ? exp_addr(sel0) : 16'h0);
        end
        wr(GMC_ADDR_MODE0, 8'h00);
        selb = 1'b0;
        drv_val = 1'b0;
        drv_en = 1'b1;
        wr(GMC_ADDR_MODE0, {5'b0, GMC_MODE_CONTROL});
        repeat (6) @(negedge clk);
        chk(pin_oe, 1'b0);
        for (i = 0; i < 6; i++)
        begin
            {drv_val, selb} = ctl_seq[i];
            wait_upd();
        end
        // mid-run reset while the pin is driven
        wr(GMC_ADDR_MODE0, {5'b0, GMC_MODE_OUTPUT});
        outv = 1'b1;
        drv_en = 1'b0;
        repeat (3) @(negedge clk);
        chk(pin_o, 1'b1);
        resetn = 1'b0;
        @(negedge clk);
        chk(pin_oe, 1'b0);
        chk(pin_o, 1'b0);
        resetn = 1'b1;
        rd(GMC_ADDR_MODE0);
        chk(d, GMC_MODE0_RESET);
        chk(pin_oe, 1'b0);
        end_sim();
    end
endmodule // gmc_gpio_mode_control_tb_top
